// *** dch_pkg.sv ***
package dch_pkg;

  // ----------------------------------------------------------------------
  // register offsets (byte addresses, one aligned word each)
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL  = 8'h00; // global enables and dma reset
  localparam logic [7:0] REG_CHEN  = 8'h04; // channel enables and modes
  localparam logic [7:0] REG_STAT  = 8'h08; // pending flags and state
  localparam logic [7:0] REG_WMARK = 8'h0c; // transmit watermark in bytes
  localparam logic [7:0] REG_XCNT  = 8'h10; // live byte counts, ports a/c

  // ----------------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------------
  localparam int CTRL_W      = 5;
  localparam int CTRL_DMA_RESET_BIT = 0;  // dma_reset_bit
  localparam int CTRL_TXDMA  = 1;  // tx_dma_enable
  localparam int CTRL_TXFIFO = 2;  // tx_fifo_enable
  localparam int CTRL_RXDMA  = 3;  // rx_dma_enable
  localparam int CTRL_RXFIFO = 4;  // rx_fifo_enable
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;

  // ----------------------------------------------------------------------
  // channel enable register fields
  // ----------------------------------------------------------------------
  localparam int CHEN_W      = 19;
  localparam int CHEN_TXCE   = 0;  // transmit channel 2 enable
  localparam int CHEN_RXCE   = 1;  // receive subchannels a..d, 4 bits
  localparam int CHEN_XCE    = 5;  // external channels 3..6, 4 bits
  localparam int CHEN_REQ    = 9;  // request source external, 4 bits
  localparam int CHEN_M2M    = 13; // memory-to-memory mode, 4 bits
  localparam int CHEN_PIN    = 17; // handshake pins routed, ports a/c
  localparam logic [CHEN_W-1:0] CHEN_RST = 19'h00000;

  // ----------------------------------------------------------------------
  // status register fields
  // ----------------------------------------------------------------------
  localparam int ST_NOT_READY_PENDING    = 0;  // not_ready_pending, write one clears
  localparam int ST_NORMAL_COMPLETION_PENDING    = 1;  // normal_completion_pending, 4 bits
  localparam int ST_TXSTALL = 5;  // transmit channel stalled
  localparam int ST_RXSEL   = 6;  // last chosen subchannel, 2 bits
  localparam int ST_RXHIT   = 8;  // last search found a buffer
  localparam int ST_TXSEND  = 9;  // transmission released

  // ----------------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------------
  localparam int WMARK_W = 10;
  localparam logic [WMARK_W-1:0] WMARK_RST = 10'h100;
  localparam int CNT_W = 16;

  // external handshake engine state, one per port
  typedef enum logic [1:0] {
    XS_IDLE  = 2'b00,  // waiting for an eligible channel
    XS_MOVE  = 2'b01,  // transaction (source read in m2m mode)
    XS_DEST  = 2'b10,  // destination write in m2m mode
    XS_CLOSE = 2'b11   // retire current descriptor
  } dch_xs_t;

endpackage

// *** dch_top.sv ***
module dch_top #(
  parameter int BEAT_BYTES = 4  // bytes moved per bus transaction
) (
  input  wire logic        CLOCK,              // system clock, 50 mhz
  input  wire logic        NRST,               // async reset, active low
  input  wire logic [7:0]  AVS_ADDRESS,        // byte address
  input  wire logic        AVS_READ,           // read strobe
  input  wire logic        AVS_WRITE,          // write strobe
  input  wire logic [3:0]  AVS_BYTEENABLE,     // write byte lanes
  input  wire logic [31:0] AVS_WRITEDATA,      // write data
  output logic      [31:0] AVS_READDATA,       // read data
  output logic             AVS_WAITREQUEST,    // stall the master
  input  wire logic        LATE_COLLISION_FLAG,// tx status late collision
  input  wire logic        TX_UNDERRUN_FLAG,   // tx status underrun
  input  wire logic        TX_DESC_FULL,       // current descriptor full
  input  wire logic [15:0] TX_DESC_STATUS,     // current descriptor status
  input  wire logic        TX_FRAME_DONE,      // frame dma complete pulse
  input  wire logic        TX_FRAME_FINAL,     // descriptor frame-final
  input  wire logic [9:0]  TX_FIFO_LEVEL,      // bytes in transmit fifo
  input  wire logic        TX_SENT,            // mac finished the packet
  output logic             TX_ADVANCE,         // tx channel may progress
  output logic             TX_RESTART,         // rewind to list head pulse
  output logic             TX_SEND,            // release packet to mac
  input  wire logic        RX_FRAME_VALID,     // frame ready for search
  input  wire logic [15:0] RX_FRAME_LEN,       // frame length in bytes
  input  wire logic [3:0]  RX_BUF_READY,       // subchannel buffer ready
  input  wire logic [63:0] RX_BUF_SIZE,        // sizes a..d, 16 bits each
  input  wire logic        RX_FIFO_FULL,       // receive fifo full
  input  wire logic        RX_IN_FRAME,        // packet being received
  output logic             RX_GRANT,           // buffer chosen pulse
  output logic      [1:0]  RX_SUBCHANNEL,      // chosen subchannel
  output logic             RX_NOT_READY_IRQ,   // not-ready pending level
  input  wire logic [1:0]  XFER_REQUEST_N,     // request, ports a/c
  output logic      [1:0]  XFER_ACKNOWLEDGE_N, // acknowledge, ports a/c
  input  wire logic [1:0]  DONE_IN_N,          // retire request, a/c
  output logic      [1:0]  DONE_OUT_N,         // last buffer retired
  output logic      [1:0]  XFER_GO,            // bus transaction request
  output logic      [1:0]  XFER_READ,          // source read phase
  output logic      [1:0]  XFER_UPPER,         // channel 5/6 not 3/4
  input  wire logic [1:0]  XFER_DONE,          // transaction finished
  input  wire logic [1:0]  DESC_LAST,          // descriptor last flag
  input  wire logic [1:0]  DESC_EMPTY,         // buffer count exhausted
  output logic      [1:0]  DESC_CLOSE,         // close descriptor pulse
  output logic      [31:0] DESC_LENGTH         // byte counts, a low
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [dch_pkg::CTRL_W-1:0]  ctrl;      // control register
    logic [dch_pkg::CHEN_W-1:0]  chen;      // channel register
    logic [dch_pkg::WMARK_W-1:0] wmark;     // watermark
    logic                        not_ready_pending;      // not_ready_pending
    logic [3:0]                  normal_completion_pending;      // completion, ch 3..6
    logic                        hit;       // last search succeeded
    logic                        stall;     // tx stall seen
    logic                        rec_arm;   // tx fully disabled seen
    logic                        advance;   // tx progress allowed
    logic                        restart;   // rewind pulse
    logic                        send;      // packet released
    logic                        grant;     // rx grant pulse
    logic [1:0]                  sub;       // chosen subchannel
    logic [1:0]                  req_s1;    // request sync stage 1
    logic [1:0]                  req_s2;    // request sync stage 2
    logic [1:0]                  done_s1;   // done sync stage 1
    logic [1:0]                  done_s2;   // done sync stage 2
    dch_pkg::dch_xs_t [1:0]      xs;        // per-port engine state
    logic [1:0]                  upper;     // active channel is 5/6
    logic [1:0]                  done_seen; // done caught during ack
    logic [1:0][15:0]            cnt;       // bytes moved
    logic [1:0]                  ack_n;     // acknowledge pins
    logic [1:0]                  dout_n;    // done output pins
    logic [1:0]                  go;        // bus requests
    logic [1:0]                  rd;        // source phase
    logic [1:0]                  close;     // close pulses
    logic [1:0][15:0]            len;       // lengths left to descriptor
    logic                        waitreq;   // bus wait
    logic [31:0]                 rdata;     // bus read data
  } dch_st_t;

  localparam dch_st_t ST_RST = '{
    ctrl: dch_pkg::CTRL_RST, chen: dch_pkg::CHEN_RST,
    wmark: dch_pkg::WMARK_RST,
    req_s1: 2'h3, req_s2: 2'h3, done_s1: 2'h3, done_s2: 2'h3,
    xs: '{dch_pkg::XS_IDLE, dch_pkg::XS_IDLE},
    ack_n: 2'h3, dout_n: 2'h3, waitreq: 1'b1, default: '0};

  dch_st_t q;  // registered state
  dch_st_t d;  // next state

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // merge write data into a register under the byte enables
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // receive buffer search: returns {hit, index, not_ready_seen or no hit}
  function automatic logic [3:0] rx_search(input logic [3:0]  ce,
                                           input logic [3:0]  rdy,
                                           input logic [63:0] sz,
                                           input logic [15:0] flen);
    logic       stop;
    logic       h;
    logic       nr;
    logic [1:0] idx;
    stop = 1'b0;
    h    = 1'b0;
    nr   = 1'b0;
    idx  = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (!stop) begin
        if (!ce[i]) begin
          stop = 1'b1;
        end else if (!rdy[i]) begin
          nr = 1'b1;  // skipped, but remembered for the interrupt
        end else if (sz[16*i +: 16] >= flen) begin
          h    = 1'b1;
          idx  = 2'(i);
          stop = 1'b1;
        end
      end
    end
    return {h, idx, nr | ~h};
  endfunction

  // channel index 0..3 (ch 3..6) served by a port slot
  function automatic int chan_idx(input int port, input logic up);
    return port + (up ? 2 : 0);
  endfunction

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    dch_st_t     keep;
    logic [3:0]  srch;
    logic [3:0]  elig;
    logic [3:0]  xce;
    logic [3:0]  xreq;
    logic [3:0]  xm2m;
    logic [31:0] stat;
    logic        m2m;
    logic        hit_w;
    int          ci;
    d    = q;
    keep = q;
    srch = 4'h0;
    elig = 4'h0;
    hit_w = 1'b0;
    stat = 32'h0;
    m2m  = 1'b0;
    ci   = 0;
    xce  = q.chen[dch_pkg::CHEN_XCE +: 4];
    xreq = q.chen[dch_pkg::CHEN_REQ +: 4];
    xm2m = q.chen[dch_pkg::CHEN_M2M +: 4];

    d.req_s1  = XFER_REQUEST_N;
    d.req_s2  = q.req_s1;
    d.done_s1 = DONE_IN_N;
    d.done_s2 = q.done_s1;

    // one-cycle pulses fall back by default
    d.restart = 1'b0;
    d.grant   = 1'b0;
    d.close   = 2'h0;
    d.dout_n  = 2'h3;

    // channel eligibility: self paced, or request low on routed pins
    for (int c = 0; c < 4; c++) begin
      // external pacing needs source bit and routing
      elig[c] = xce[c] & (~xreq[c] |
                (q.chen[dch_pkg::CHEN_PIN + (c % 2)] & ~q.req_s2[c % 2]));
    end

    // transmit stall and recovery
    // stall on flagged zero-status full descriptor
    d.stall = (LATE_COLLISION_FLAG | TX_UNDERRUN_FLAG) & TX_DESC_FULL &
              (TX_DESC_STATUS == 16'h0000);
    d.advance = q.chen[dch_pkg::CHEN_TXCE] & q.ctrl[dch_pkg::CTRL_TXDMA] &
                q.ctrl[dch_pkg::CTRL_TXFIFO] & ~d.stall;
    // full disable then enable rewinds the list
    if (!q.chen[dch_pkg::CHEN_TXCE] && !q.ctrl[dch_pkg::CTRL_TXDMA] &&
        !q.ctrl[dch_pkg::CTRL_TXFIFO]) begin
      d.rec_arm = 1'b1;
    end else if (q.rec_arm && q.chen[dch_pkg::CHEN_TXCE] &&
                 q.ctrl[dch_pkg::CTRL_TXDMA] &&
                 q.ctrl[dch_pkg::CTRL_TXFIFO]) begin
      d.rec_arm = 1'b0;
      d.restart = 1'b1;
    end

    // packet release toward the mac
    if (!q.ctrl[dch_pkg::CTRL_TXFIFO] || TX_SENT) begin
      d.send = 1'b0;
    end else if (TX_FRAME_DONE && TX_FRAME_FINAL) begin
      d.send = 1'b1;
    end else if (TX_FIFO_LEVEL != 10'h000 &&
                 TX_FIFO_LEVEL >= q.wmark) begin
      d.send = 1'b1;
    end

    // receive buffer selection
    hit_w = 1'b0;
    if (RX_FRAME_VALID && q.ctrl[dch_pkg::CTRL_RXDMA] &&
        q.ctrl[dch_pkg::CTRL_RXFIFO]) begin
      srch    = rx_search(q.chen[dch_pkg::CHEN_RXCE +: 4], RX_BUF_READY,
                          RX_BUF_SIZE, RX_FRAME_LEN);
      d.hit   = srch[3];
      d.grant = srch[3];
      d.sub   = srch[3] ? srch[2:1] : q.sub;
      hit_w   = srch[0];
    end

    // external handshake engines, one per port
    // port 0 serves ch 3/5, port 1 serves ch 4/6
    for (int p = 0; p < 2; p++) begin
      ci  = chan_idx(p, q.upper[p]);
      m2m = xm2m[ci];
      if (q.xs[p] != dch_pkg::XS_IDLE && !q.ack_n[p] && !q.done_s2[p]) begin
        d.done_seen[p] = 1'b1;  // done honoured only under acknowledge
      end
      unique case (q.xs[p])
        dch_pkg::XS_IDLE: begin
          // lower channel number has priority on a shared port
          if (elig[p] || elig[p + 2]) begin
            d.upper[p]     = ~elig[p];
            d.xs[p]        = dch_pkg::XS_MOVE;
            d.cnt[p]       = 16'h0000;
            d.done_seen[p] = 1'b0;
          end
        end
        dch_pkg::XS_MOVE: begin
          if (XFER_DONE[p]) begin
            d.cnt[p] = q.cnt[p] + 16'(BEAT_BYTES);
            // read phase is followed by a write
            if (m2m) begin
              d.xs[p] = dch_pkg::XS_DEST;
            end else if (d.done_seen[p] || DESC_EMPTY[p]) begin
              d.xs[p] = dch_pkg::XS_CLOSE;
            end else if (!elig[ci]) begin
              d.xs[p] = dch_pkg::XS_IDLE;  // paced off: resume later
            end
          end
        end
        dch_pkg::XS_DEST: begin
          if (XFER_DONE[p]) begin
            if (d.done_seen[p] || DESC_EMPTY[p]) begin
              d.xs[p] = dch_pkg::XS_CLOSE;
            end else if (elig[ci]) begin
              d.xs[p] = dch_pkg::XS_MOVE;
            end else begin
              d.xs[p] = dch_pkg::XS_IDLE;
            end
          end
        end
        dch_pkg::XS_CLOSE: begin
          // close, flag completion, leave byte count
          d.close[p]  = 1'b1;
          d.normal_completion_pending[ci]  = 1'b1;
          d.len[p]    = q.cnt[p];
          // done output when the closed descriptor is the last
          d.dout_n[p] = ~DESC_LAST[p];
          d.xs[p]     = dch_pkg::XS_IDLE;
        end
      endcase
      d.ack_n[p] = ~(d.xs[p] == dch_pkg::XS_MOVE ||
                     d.xs[p] == dch_pkg::XS_DEST);
      d.go[p]    = ~d.ack_n[p];
      d.rd[p]    = (d.xs[p] == dch_pkg::XS_MOVE) &
                   xm2m[chan_idx(p, d.upper[p])];
    end

    // status word as seen by software
    stat[dch_pkg::ST_NOT_READY_PENDING]        = q.not_ready_pending;
    stat[dch_pkg::ST_NORMAL_COMPLETION_PENDING +: 4]   = q.normal_completion_pending;
    stat[dch_pkg::ST_TXSTALL]     = q.stall;
    stat[dch_pkg::ST_RXSEL +: 2]  = q.sub;
    stat[dch_pkg::ST_RXHIT]       = q.hit;
    stat[dch_pkg::ST_TXSEND]      = q.send;

    // register bus: one wait cycle, then a one-cycle answer
    d.waitreq = 1'b1;
    if ((AVS_READ || AVS_WRITE) && q.waitreq) begin
      d.waitreq = 1'b0;
      unique case (AVS_ADDRESS)
        dch_pkg::REG_CTRL:  d.rdata = 32'(q.ctrl);
        dch_pkg::REG_CHEN:  d.rdata = 32'(q.chen);
        dch_pkg::REG_STAT:  d.rdata = stat;
        dch_pkg::REG_WMARK: d.rdata = 32'(q.wmark);
        dch_pkg::REG_XCNT:  d.rdata = {q.cnt[1], q.cnt[0]};
        default:            d.rdata = 32'h0;
      endcase
    end
    // writes take effect at the edge where waitrequest is seen low
    if (AVS_WRITE && !q.waitreq) begin
      unique case (AVS_ADDRESS)
        dch_pkg::REG_CTRL: begin
          d.ctrl = dch_pkg::CTRL_W'(wmerge(32'(q.ctrl), AVS_WRITEDATA,
                                           AVS_BYTEENABLE));
        end
        dch_pkg::REG_CHEN: begin
          d.chen = dch_pkg::CHEN_W'(wmerge(32'(q.chen), AVS_WRITEDATA,
                                           AVS_BYTEENABLE));
        end
        dch_pkg::REG_STAT: begin
          if (AVS_BYTEENABLE[0]) begin
            // write one clears; a same-cycle event sets it again below
            d.not_ready_pending = q.not_ready_pending & ~AVS_WRITEDATA[dch_pkg::ST_NOT_READY_PENDING];
            d.normal_completion_pending = d.normal_completion_pending & ~AVS_WRITEDATA[dch_pkg::ST_NORMAL_COMPLETION_PENDING +: 4] |
                     (d.normal_completion_pending & ~q.normal_completion_pending);
          end
        end
        dch_pkg::REG_WMARK: begin
          d.wmark = dch_pkg::WMARK_W'(wmerge(32'(q.wmark), AVS_WRITEDATA,
                                             AVS_BYTEENABLE));
        end
        default: begin
        end
      endcase
    end

    // set beats clear for the not-ready flag
    // overrun during a packet reports not-ready
    if (hit_w || (RX_FIFO_FULL && RX_IN_FRAME)) begin
      d.not_ready_pending = 1'b1;
    end

    // dma reset bit holds all channels in reset
    if (q.ctrl[dch_pkg::CTRL_DMA_RESET_BIT]) begin
      keep      = d;
      d         = ST_RST;
      d.ctrl    = keep.ctrl;
      d.chen    = keep.chen;
      d.wmark   = keep.wmark;
      d.req_s1  = keep.req_s1;
      d.req_s2  = keep.req_s2;
      d.done_s1 = keep.done_s1;
      d.done_s2 = keep.done_s2;
      d.waitreq = keep.waitreq;
      d.rdata   = keep.rdata;
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  // every hardware reset clears all channels as well
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, straight from the state register
  // ----------------------------------------------------------------------
  assign AVS_READDATA       = q.rdata;
  assign AVS_WAITREQUEST    = q.waitreq;
  assign TX_ADVANCE         = q.advance;
  assign TX_RESTART         = q.restart;
  assign TX_SEND            = q.send;
  assign RX_GRANT           = q.grant;
  assign RX_SUBCHANNEL      = q.sub;
  assign RX_NOT_READY_IRQ   = q.not_ready_pending;
  assign XFER_ACKNOWLEDGE_N = q.ack_n;
  assign DONE_OUT_N         = q.dout_n;
  assign XFER_GO            = q.go;
  assign XFER_READ          = q.rd;
  assign XFER_UPPER         = q.upper;
  assign DESC_CLOSE         = q.close;
  assign DESC_LENGTH        = {q.len[1], q.len[0]};

endmodule // dch_top

// *** dch_props.sv ***
module dch_props (
  input wire logic        CLOCK,               // system clock
  input wire logic        NRST,                // reset, active low
  input wire logic        AVS_READ,            // read strobe
  input wire logic        AVS_WRITE,           // write strobe
  input wire logic        AVS_WAITREQUEST,     // bus stall
  input wire logic        LATE_COLLISION_FLAG, // tx late collision
  input wire logic        TX_DESC_FULL,        // descriptor full
  input wire logic [15:0] TX_DESC_STATUS,      // descriptor status
  input wire logic        TX_FRAME_DONE,       // frame dma done
  input wire logic        TX_FRAME_FINAL,      // frame-final flag
  input wire logic        TX_SENT,             // packet finished
  input wire logic        TX_ADVANCE,          // tx may progress
  input wire logic        TX_RESTART,          // rewind pulse
  input wire logic        TX_SEND,             // packet released
  input wire logic        RX_FRAME_VALID,      // frame to place
  input wire logic        RX_GRANT,            // buffer chosen
  input wire logic [1:0]  XFER_ACKNOWLEDGE_N,  // acknowledge
  input wire logic [1:0]  XFER_GO,             // transaction
  input wire logic [1:0]  DONE_OUT_N,          // last retired
  input wire logic [1:0]  DESC_CLOSE           // close pulse
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_bus_one_wait: assert property ((AVS_READ || AVS_WRITE) &&
    AVS_WAITREQUEST |=> !AVS_WAITREQUEST) else $error("no answer");
  a_ack_go_match: assert property (XFER_GO == ~XFER_ACKNOWLEDGE_N)
    else $error("go and acknowledge disagree");
  // three cycles cover the registered stall term
  a_stall_hold: assert property ((LATE_COLLISION_FLAG && TX_DESC_FULL &&
    TX_DESC_STATUS == 16'h0000) [*3] |-> !TX_ADVANCE)
    else $error("tx moved while stalled");
  a_final_send: assert property (TX_FRAME_DONE && TX_FRAME_FINAL &&
    TX_ADVANCE && !TX_SENT |=> TX_SEND) else $error("final not sent");
  a_grant_cause: assert property (RX_GRANT |-> $past(RX_FRAME_VALID))
    else $error("grant without frame");
  a_done_close: assert property (!DONE_OUT_N[0] |-> DESC_CLOSE[0])
    else $error("done without close");
  a_done_pulse: assert property (!DONE_OUT_N[0] |=> DONE_OUT_N[0])
    else $error("done longer than a cycle");
  a_restart_pulse: assert property (TX_RESTART |=> !TX_RESTART)
    else $error("restart longer than a cycle");
  c_done: cover property (!DONE_OUT_N[0]);
  c_restart: cover property (TX_RESTART);
  c_grant: cover property (RX_GRANT);
endmodule // dch_props
bind dch_top dch_props dch_props_inst (.*);

// *** dch_periph.sv ***
module dch_periph (
  input  wire logic CLOCK,  // system clock
  input  wire logic en,     // start requesting
  input  wire logic ack_n,  // acknowledge from block
  input  wire logic go,     // transaction open
  output logic      req_n,  // request, active low
  output logic      xdone,  // transaction finished
  output logic      done_n  // retire, active low
);
  logic [3:0] beats;  // transactions finished
  logic [1:0] lag;    // wait inside a transaction
  initial begin
    {req_n, done_n, xdone, beats, lag} = {2'b11, 7'h00};
  end
  // odd beats answer slowly, even beats at once
  always @(posedge CLOCK) begin
    xdone <= 1'b0;
    req_n <= !(en && beats < 4'h4);
    if (go && !xdone) begin
      lag <= lag + 2'h1;
      if (lag == (beats[0] ? 2'h2 : 2'h0)) begin
        xdone <= 1'b1;
        lag <= 2'h0;
        beats <= beats + 4'h1;
      end
    end
    done_n <= !(beats == 4'h3 && !ack_n);
  end
endmodule // dch_periph

// *** dch_top_tb.sv ***
module dch_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLOCK = 0, NRST = 0, rd = 0, wr = 0, lc = 0, uf = 0, ff = 0;
  logic pen = 0, ovr = 0;
  logic [2:0] pv = 3'h0;  // pulses: [0] sent, [1] frame done, [2] frame
  logic [7:0] ad = 8'h00;
  logic [31:0] wd = 32'h0, rdata, dl, st = 32'h4515404d;
  logic [9:0] lvl = 10'h000;
  logic [15:0] flen = 16'h0000;
  logic [3:0] rdy = 4'hf;
  logic [1:0] ackn, go, don, dc, sub, nrs = 2'h0;
  logic req, xd, dn, wt, adv, snd, irq, rs, gr;
  logic [63:0] q[$];
  int fails = 0, checked = 0, ng = 0;
  always #10 CLOCK = ~CLOCK;
  dch_top dch_top_inst (.CLOCK(CLOCK), .NRST(NRST), .AVS_ADDRESS(ad),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_BYTEENABLE(4'hf),
    .AVS_WRITEDATA(wd), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wt),
    .LATE_COLLISION_FLAG(lc), .TX_UNDERRUN_FLAG(uf),
    .TX_DESC_FULL(lc), .TX_DESC_STATUS(16'h0000), .TX_FRAME_DONE(pv[1]),
    .TX_FRAME_FINAL(ff), .TX_FIFO_LEVEL(lvl), .TX_SENT(pv[0]),
    .TX_ADVANCE(adv), .TX_RESTART(rs), .TX_SEND(snd),
    .RX_FRAME_VALID(pv[2]), .RX_FRAME_LEN(flen), .RX_BUF_READY(rdy),
    .RX_BUF_SIZE(64'h0800_0400_0100_0040), .RX_FIFO_FULL(ovr),
    .RX_IN_FRAME(ovr), .RX_GRANT(gr), .RX_SUBCHANNEL(sub),
    .RX_NOT_READY_IRQ(irq), .XFER_REQUEST_N({1'b1, req}),
    .XFER_ACKNOWLEDGE_N(ackn), .DONE_IN_N({1'b1, dn}), .DONE_OUT_N(don),
    .XFER_GO(go), .XFER_READ(), .XFER_UPPER(), .XFER_DONE({1'b0, xd}),
    .DESC_LAST(2'b01), .DESC_EMPTY(2'b00), .DESC_CLOSE(dc),
    .DESC_LENGTH(dl));
  dch_periph dch_periph_inst (.CLOCK(CLOCK), .en(pen), .ack_n(ackn[0]),
    .go(go[0]), .req_n(req), .xdone(xd), .done_n(dn));
  // count rewind pulses for the recovery check and grant pulses for the end-of-run check
  always @(posedge CLOCK) begin
    if (rs === 1'b1) nrs <= nrs + 2'h1;
    if (gr === 1'b1) ng <= ng + 1;
  end
  // xorshift step for random stimulus
  function automatic logic [31:0] xs32(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    checked++;
    if (a !== e) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, a, e);
    end
  endtask
  // read results are paired with the oldest note
  always @(posedge CLOCK) if (rd && wt === 1'b0) begin
    chk(rdata & q[0][63:32], q[0][31:0]);
    void'(q.pop_front());
  end
  task automatic acc(input logic [7:0] a, input logic w,
      input logic [31:0] d, input logic [31:0] m);
    if (!w) q.push_back({m, d & m});
    @(posedge CLOCK);
    ad <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    // the wait ends once waitrequest is seen low
    do @(posedge CLOCK); while (wt !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic pulse(input logic [2:0] m);
    @(posedge CLOCK) pv <= m;
    @(posedge CLOCK) pv <= 3'h0;
    repeat (3) @(posedge CLOCK);
  endtask
  task automatic tally_and_finish();
    $display("fails %0d checked %0d", fails, checked);
    if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge CLOCK);
    fails++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge CLOCK);
    NRST <= 1'b1;
    chk({ackn, don, wt}, 32'h1f);
    acc(8'h0c, 0, 32'h100, '1);
    acc(8'h14, 0, 32'h0, '1);
    acc(8'h00, 1, 32'h1e, '1);
    acc(8'h04, 1, 32'h20227, '1);
    acc(8'h0c, 1, 32'h4, '1);
    acc(8'h04, 0, 32'h20227, '1);
    lvl <= 10'h003;
    repeat (4) @(posedge CLOCK);
    chk(snd, 1'b0);
    lvl <= 10'h004;
    repeat (4) @(posedge CLOCK);
    chk(snd, 1'b1);
    lvl <= 10'h000;
    pulse(3'h1);
    chk(snd, 1'b0);
    ff <= 1'b1;
    pulse(3'h2);
    chk(snd, 1'b1);
    pulse(3'h1);
    flen <= 16'h0064;
    pulse(3'h4);
    chk({sub, irq}, 3'h2);
    st = xs32(st);
    flen <= {10'h000, st[5:0]} + 16'h1;
    pulse(3'h4);
    chk({sub, irq}, 3'h0);
    rdy <= 4'he;
    pulse(3'h4);
    chk({sub, irq}, 3'h3);
    flen <= 16'h0200;
    pulse(3'h4);
    acc(8'h08, 0, 32'h40, 32'h1c0);
    acc(8'h00, 1, 32'h1f, '1);
    acc(8'h00, 1, 32'h1e, '1);
    chk(irq, 1'b0);
    ovr <= 1'b1;
    pulse(3'h0);
    ovr <= 1'b0;
    chk(irq, 1'b1);
    acc(8'h00, 1, 32'h16, '1);
    acc(8'h00, 1, 32'h06, '1);
    acc(8'h04, 1, 32'h20221, '1);
    rdy <= 4'hf;
    acc(8'h04, 1, 32'h20227, '1);
    acc(8'h00, 1, 32'h16, '1);
    acc(8'h00, 1, 32'h1e, '1);
    acc(8'h08, 1, 32'h1, '1);
    @(posedge CLOCK);
    chk(irq, 1'b0);
    flen <= 16'h0041;
    pulse(3'h4);
    chk({sub, irq}, 3'h2);
    acc(8'h00, 0, 32'h1e, '1);
    uf <= 1'b1;
    repeat (4) @(posedge CLOCK);
    chk(adv, 1'b1);
    lc <= 1'b1;
    repeat (4) @(posedge CLOCK);
    chk(adv, 1'b0);
    lc <= 1'b0;
    uf <= 1'b0;
    // underrun recovery in its ordered steps
    acc(8'h04, 1, 32'h20226, '1);
    acc(8'h00, 1, 32'h18, '1);
    acc(8'h00, 1, 32'h1e, '1);
    acc(8'h04, 1, 32'h20227, '1);
    repeat (3) @(posedge CLOCK);
    chk({adv, nrs}, 3'h6);
    pen <= 1'b1;
    for (int n = 0; n < 200 && don[0] !== 1'b0; n++) @(posedge CLOCK);
    chk({don[0], dc[0]}, 2'h1);
    chk(dl[15:0], 16'h0010);
    acc(8'h08, 0, 32'h2, 32'h2);
    chk(ng, 32'h4);
    tally_and_finish();
  end
endmodule // dch_top_tb
